// ### cop1_control.sv
/*
  Charge option one control register with its monitor gating, comparator
  conditioning and forced path-off latch.
  Assumes a register port decoded from the SMBus word protocol on clk, a
  low-power-mode level from the option zero register on the same clock, and
  a comparator input that arrives asynchronously from the analog front end.
*/
// Behaviour
// - register answers command 30h and powers up holding 211h.
// - bit 15 turns the battery current monitor buffer on; resets to 0.
// - low power mode forces the battery current monitor buffer off.
// - bits 14-13 pick the low power hot alert source; 00 resets.
// - bit 12 turns system power sensing and buffer on; resets to 0.
// - low power mode forces system power sensing and buffer off.
// - bit 11 picks input sense resistor, 10 or 20 milliohm.
// - bit 10 picks charge sense resistor, 10 or 20 milliohm.
// - bit 9 picks power monitor gain, 0.25 or 1 microamp per watt.
// - bit 7 picks comparator reference, 2.3 V or 1.2 V.
// - bit 6 sets which side of threshold drives the output low.
// - bits 5-4 disable comparator or pick 1 us, 2 ms, 5 s deglitch.
// - deglitch delays only the high to low output transition.
// - with bit 3 set, a comparator trip turns both input switches off.
// - charger good indicator drops low as the forced path-off occurs.
`timescale 1ns/10ps
`include "cop1_params.svh"
module cop1_control #(
  parameter cop1_pkg::cop1_cnt_t DEG_MID_CYC  = cop1_pkg::cop1_cnt_t'(`COP1_DEG_MID_CYC),
  parameter cop1_pkg::cop1_cnt_t DEG_LONG_CYC = cop1_pkg::cop1_cnt_t'(`COP1_DEG_LONG_CYC)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  cmdCode,
  input  wire logic        wrStb,
  input  wire logic [15:0] wrData,
  output logic      [15:0] rdData,
  input  wire logic        lowPowerMode,
  input  wire logic        comparatorInput,
  input  wire logic        chargerGoodIn,
  output logic             batteryCurrentMonitorEnable,
  output logic             systemPowerMonitorEnable,
  output logic      [1:0]  lowPowerHotAlertSelect,
  output logic             inputSenseResistorSelect,
  output logic             chargeSenseResistorSelect,
  output logic             powerMonitorGainSelect,
  output logic             comparatorReferenceSelect,
  output logic             comparatorOutput,
  output logic             inputSwitchesOff,
  output logic             chargerGoodIndicator
);
  import cop1_pkg::*;

  localparam cop1_cnt_t DEG_SHORT_CYC = cop1_cnt_t'(`COP1_DEG_SHORT_CYC);

  cop1_state_t s_q;
  cop1_state_t s_d;
  cop1_deg_t   degCode;
  cop1_cnt_t   holdCycles;
  logic        cmpEnable;
  logic        comparator_output;
  logic        trip;

  // --------------------------------------------------------------------------
  // comparator conditioning
  // --------------------------------------------------------------------------
  function automatic cop1_cnt_t deg_cycles(input cop1_deg_t code);
    case (code)
      COP1_DEG_MID:  deg_cycles = DEG_MID_CYC;
      COP1_DEG_LONG: deg_cycles = DEG_LONG_CYC;
      default:       deg_cycles = DEG_SHORT_CYC;
    endcase
  endfunction

  assign degCode    = cop1_deg_t'(s_q.regVal[`COP1_BIT_DEG_HI:`COP1_BIT_DEG_LO]);
  assign cmpEnable  = (degCode != COP1_DEG_OFF);
  assign holdCycles = deg_cycles(degCode);

  cop1_deglitch u_deglitch (
    .clk        (clk),
    .nrst       (nrst),
    .enable     (cmpEnable),
    .level      (s_q.cmpLevel),
    .holdCycles (holdCycles),
    .out        (comparator_output)
  );

  assign trip = cmpEnable && !comparator_output;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (wrStb && cmdCode == `COP1_CMD_CODE) begin
      s_d.regVal = wrData;
    end
    s_d.rdData   = (cmdCode == `COP1_CMD_CODE) ? s_q.regVal : 16'h0000;
    s_d.cmpSync1 = comparatorInput;
    s_d.cmpSync2 = s_q.cmpSync1;
    s_d.cmpSync3 = s_q.cmpSync2;
    if (s_q.cmpSync2 == s_q.cmpSync3) begin
      s_d.cmpStable = s_q.cmpSync3;
    end
    // stable input means above threshold
    s_d.cmpLevel = s_q.regVal[`COP1_BIT_COMPARATOR_POLARITY_SELECT] ? s_q.cmpStable : !s_q.cmpStable;
    s_d.batMonOn = s_q.regVal[`COP1_BIT_BAT_MON] && !lowPowerMode;
    s_d.sysMonOn = s_q.regVal[`COP1_BIT_SYS_MON] && !lowPowerMode;
    if (s_q.regVal[`COP1_BIT_HOT_HI:`COP1_BIT_HOT_LO] == 2'b11) begin
      s_d.hotSel = 2'b00;
    end else begin
      s_d.hotSel = s_q.regVal[`COP1_BIT_HOT_HI:`COP1_BIT_HOT_LO];
    end
    // latched until software clears the force bit
    s_d.pathOff = s_q.regVal[`COP1_BIT_FORCE_OFF] && (s_q.pathOff || trip);
    s_d.chgGood = chargerGoodIn && !s_d.pathOff;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q        <= '0;
      s_q.regVal <= `COP1_RESET_VALUE;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign rdData                      = s_q.rdData;
  assign batteryCurrentMonitorEnable = s_q.batMonOn;
  assign systemPowerMonitorEnable    = s_q.sysMonOn;
  assign lowPowerHotAlertSelect      = s_q.hotSel;
  assign inputSenseResistorSelect    = s_q.regVal[`COP1_BIT_IN_RSNS];
  assign chargeSenseResistorSelect   = s_q.regVal[`COP1_BIT_CHG_RSNS];
  assign powerMonitorGainSelect      = s_q.regVal[`COP1_BIT_GAIN];
  assign comparatorReferenceSelect   = s_q.regVal[`COP1_BIT_COMPARATOR_REFERENCE_SELECT];
  assign comparatorOutput            = comparator_output;
  assign inputSwitchesOff            = s_q.pathOff;
  assign chargerGoodIndicator        = s_q.chgGood;

  // --------------------------------------------------------------------------
  // check helpers
  // --------------------------------------------------------------------------
  // consecutive low level samples while the comparator runs
  cop1_cnt_t lowRun_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowRun_q <= '0;
    end else if (cmpEnable && !s_q.cmpLevel) begin
      if (lowRun_q != '1) begin
        lowRun_q <= lowRun_q + cop1_cnt_t'(1);
      end
    end else begin
      lowRun_q <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence wordWritten;
    wrStb && cmdCode == `COP1_CMD_CODE ##1 cmdCode == `COP1_CMD_CODE;
  endsequence

  sequence forcedTrip;
    s_q.regVal[`COP1_BIT_FORCE_OFF] && trip;
  endsequence

  a_reset_value: assert property (!$past(nrst) |-> s_q.regVal == `COP1_RESET_VALUE)
    else $error("register not at reset value after reset");
  a_write_read: assert property (wordWritten |=> rdData == $past(wrData, 2))
    else $error("read back differs from written word");
  a_reg_write: assert property (wrStb && cmdCode == `COP1_CMD_CODE |=> s_q.regVal == $past(wrData))
    else $error("register did not take the written word");
  a_read_other: assert property (cmdCode != `COP1_CMD_CODE |=> rdData == 16'h0000)
    else $error("other command code read nonzero");
  a_bat_gate: assert property (lowPowerMode |=> !batteryCurrentMonitorEnable)
    else $error("battery monitor on in low power mode");
  a_bat_enable: assert property (s_q.regVal[15] && !lowPowerMode |=> batteryCurrentMonitorEnable)
    else $error("battery monitor not on when enabled");
  a_sys_gate: assert property ((lowPowerMode || !s_q.regVal[12]) |=> !systemPowerMonitorEnable)
    else $error("system power sensing on while gated");
  a_sys_enable: assert property (s_q.regVal[`COP1_BIT_SYS_MON] && !lowPowerMode |=> systemPowerMonitorEnable)
    else $error("system power sensing not on when enabled");
  a_hot_code: assert property (lowPowerHotAlertSelect != 2'b11)
    else $error("reserved hot alert code driven");
  a_hot_discharge: assert property (s_q.regVal[14:13] == 2'b01 |=> lowPowerHotAlertSelect == 2'b01)
    else $error("discharge current hot alert not selected");
  a_hot_voltage: assert property (s_q.regVal[14:13] == 2'b10 |=> lowPowerHotAlertSelect == 2'b10)
    else $error("system voltage hot alert not selected");
  a_hot_reserved: assert property (s_q.regVal[14:13] == 2'b11 |=> lowPowerHotAlertSelect == 2'b00)
    else $error("reserved hot alert code not treated as disabled");
  a_sync_agree: assert property ($changed(s_q.cmpStable) |-> $past(s_q.cmpSync2) == $past(s_q.cmpSync3))
    else $error("comparator input accepted before two stages agreed");
  a_pol_level: assert property (cmpEnable && s_q.cmpStable && !s_q.regVal[6] |=> !s_q.cmpLevel)
    else $error("polarity zero does not pull level low above threshold");
  a_pol_high: assert property (s_q.cmpStable && s_q.regVal[`COP1_BIT_COMPARATOR_POLARITY_SELECT] |=> s_q.cmpLevel)
    else $error("polarity one pulls level low above threshold");
  a_cmp_off: assert property (degCode == COP1_DEG_OFF |=> comparatorOutput)
    else $error("disabled comparator output not high");
  a_rise_fast: assert property (cmpEnable && s_q.cmpLevel |=> comparatorOutput)
    else $error("comparator rise was delayed");
  a_fall_taken: assert property (cmpEnable && !s_q.cmpLevel
                                 && lowRun_q >= holdCycles - cop1_cnt_t'(1) |=> !comparatorOutput)
    else $error("deglitched fall not taken after hold time");
  a_no_early: assert property ($fell(comparatorOutput) |-> !$past(s_q.cmpLevel)
                               && $past(lowRun_q) >= $past(holdCycles) - cop1_cnt_t'(1))
    else $error("comparator fell before hold time");
  a_path_off: assert property (forcedTrip |=> inputSwitchesOff)
    else $error("forced path-off did not open switches");
  a_path_hold: assert property (inputSwitchesOff && s_q.regVal[`COP1_BIT_FORCE_OFF] |=> inputSwitchesOff)
    else $error("forced path-off released while force bit set");
  a_path_clear: assert property (!s_q.regVal[`COP1_BIT_FORCE_OFF] |=> !inputSwitchesOff)
    else $error("switches held off with force bit clear");
  a_good_low: assert property (inputSwitchesOff |-> !chargerGoodIndicator)
    else $error("charger good high while path forced off");
  a_good_follow: assert property (!chargerGoodIn |=> !chargerGoodIndicator)
    else $error("charger good high without upstream good");
  a_good_pass: assert property (chargerGoodIn && !s_q.regVal[`COP1_BIT_FORCE_OFF] |=> chargerGoodIndicator)
    else $error("charger good dropped without path-off");

endmodule

// ### cop1_params.svh
/*
  Constants of the charge option one control register: command code, reset
  value, field positions and comparator deglitch timing.
  Assumes a 10 MHz core clock; included by the package and the top module.
*/
`ifndef COP1_PARAMS_SVH
`define COP1_PARAMS_SVH

// ----------------------------------------------------------------------------
// register placement
// ----------------------------------------------------------------------------
`define COP1_CMD_CODE        8'h30
`define COP1_RESET_VALUE     16'h0211

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define COP1_BIT_BAT_MON     15
`define COP1_BIT_HOT_HI      14
`define COP1_BIT_HOT_LO      13
`define COP1_BIT_SYS_MON     12
`define COP1_BIT_IN_RSNS     11
`define COP1_BIT_CHG_RSNS    10
`define COP1_BIT_GAIN        9
`define COP1_BIT_COMPARATOR_REFERENCE_SELECT     7
`define COP1_BIT_COMPARATOR_POLARITY_SELECT     6
`define COP1_BIT_DEG_HI      5
`define COP1_BIT_DEG_LO      4
`define COP1_BIT_FORCE_OFF   3

// ----------------------------------------------------------------------------
// deglitch timing
// ----------------------------------------------------------------------------
`define COP1_CLK_HZ          10000000
`define COP1_DEG_SHORT_NS    1000
`define COP1_DEG_MID_MS      2
`define COP1_DEG_LONG_S      5
`define COP1_DEG_SHORT_CYC   ((`COP1_DEG_SHORT_NS * (`COP1_CLK_HZ / 1000000)) / 1000)
`define COP1_DEG_MID_CYC     (`COP1_DEG_MID_MS * (`COP1_CLK_HZ / 1000))
`define COP1_DEG_LONG_CYC    (`COP1_DEG_LONG_S * `COP1_CLK_HZ)
`define COP1_CNT_W           26

`endif

// ### cop1_pkg.sv
/*
  Types of the charge option one control block: deglitch codes and the
  packed state records of the top module and of the deglitch filter.
  Assumes cop1_params.svh is on the include path.
*/
`include "cop1_params.svh"

package cop1_pkg;

  typedef logic [`COP1_CNT_W-1:0] cop1_cnt_t;

  typedef enum logic [1:0] {
    COP1_DEG_OFF   = 2'b00,
    COP1_DEG_SHORT = 2'b01,
    COP1_DEG_MID   = 2'b10,
    COP1_DEG_LONG  = 2'b11
  } cop1_deg_t;

  typedef struct packed {
    logic [15:0] regVal;
    logic [15:0] rdData;
    logic        cmpSync1;
    logic        cmpSync2;
    logic        cmpSync3;
    logic        cmpStable;
    logic        cmpLevel;
    logic        batMonOn;
    logic        sysMonOn;
    logic [1:0]  hotSel;
    logic        pathOff;
    logic        chgGood;
  } cop1_state_t;

  typedef struct packed {
    cop1_cnt_t cnt;
    logic      out;
  } cop1_dg_state_t;

endpackage

// ### cop1_deglitch.sv
/*
  Falling-edge deglitch filter for the comparator output: a rise passes at
  once, a fall passes only after the level stayed low for holdCycles cycles.
  Assumes level and holdCycles come from logic on the same clock.
*/
`timescale 1ns/10ps
module cop1_deglitch (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              enable,
  input  wire logic              level,
  input  wire cop1_pkg::cop1_cnt_t holdCycles,
  output logic                   out
);
  import cop1_pkg::*;

  cop1_dg_state_t s_q;
  cop1_dg_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!enable || level) begin
      s_d.out = 1'b1;
      s_d.cnt = '0;
    end else if (s_q.out) begin
      if (s_q.cnt >= holdCycles - cop1_cnt_t'(1)) begin
        s_d.out = 1'b0;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt + cop1_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{cnt: '0, out: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign out = s_q.out;

endmodule

// ### cop1_host_model.sv
/*
  Host controller model on the far side of the register port: word writes
  and word reads by command code.
  Assumes clk from the bench and the register port of cop1_control.
*/
`timescale 1ns/10ps
module cop1_host_model (
  input  wire logic        clk,
  input  wire logic        adapterPresent,
  output logic      [7:0]  cmdCode,
  output logic             wrStb,
  output logic      [15:0] wrData,
  input  wire logic [15:0] rdData
);
  initial begin
    cmdCode = 8'h00;
    wrStb   = 1'b0;
    wrData  = 16'h0000;
  end
  // ----------------------------------------------------------------------------
  // word transfers
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    @(posedge clk);
    #5;
    cmdCode = code;
    wrData  = adapterPresent ? (d & 16'h9fff) : d;
    wrStb   = 1'b1;
    @(posedge clk);
    #5;
    wrStb  = 1'b0;
    wrData = ~wrData;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] d);
    @(posedge clk);
    #5;
    cmdCode = code;
    @(posedge clk);
    #5;
    d = rdData;
  endtask
endmodule

// ### charge_option_one_control_tb.sv
/*
  Self-checking bench of cop1_control: register access, monitor gating and
  the comparator path with its path-off latch.
  Assumes cop1_pkg, cop1_host_model and cop1_control are compiled first.
*/
`timescale 1ns/10ps
module charge_option_one_control_tb;
  import cop1_pkg::*;
  localparam int MID  = 20;
  localparam int LONG = 40;
  logic clk = 1'b0, nrst = 1'b0, lowPowerMode = 1'b0, comparatorInput = 1'b0, chargerGoodIn = 1'b1;
  logic [7:0] cmdCode;
  logic [15:0] wrData, rdData, d, m;
  logic wrStb, batEn, sysEn, inSel, chgSel, gain, cmpRef, comparatorOutput, inputSwitchesOff;
  logic chargerGoodIndicator;
  logic [1:0] hot;
  logic [31:0] seed = 32'h00004142, r;
  int errors = 0, checks_done = 0, k;
  always #50 clk = ~clk;
  cop1_host_model host (.clk(clk), .adapterPresent(chargerGoodIn), .cmdCode(cmdCode), .wrStb(wrStb),
    .wrData(wrData), .rdData(rdData));
  cop1_control #(.DEG_MID_CYC(cop1_cnt_t'(MID)), .DEG_LONG_CYC(cop1_cnt_t'(LONG))) dut (.clk(clk),
    .nrst(nrst), .cmdCode(cmdCode), .wrStb(wrStb), .wrData(wrData), .rdData(rdData),
    .lowPowerMode(lowPowerMode), .comparatorInput(comparatorInput), .chargerGoodIn(chargerGoodIn),
    .batteryCurrentMonitorEnable(batEn), .systemPowerMonitorEnable(sysEn), .lowPowerHotAlertSelect(hot),
    .inputSenseResistorSelect(inSel), .chargeSenseResistorSelect(chgSel), .powerMonitorGainSelect(gain),
    .comparatorReferenceSelect(cmpRef), .comparatorOutput(comparatorOutput),
    .inputSwitchesOff(inputSwitchesOff), .chargerGoodIndicator(chargerGoodIndicator));
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic waitOut(input logic v, input int lim, output int n);
    n = 0;
    while (comparatorOutput !== v && n < lim) begin
      @(posedge clk);
      #5;
      n++;
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #5;
  endtask
  // glitch, trip, path-off, release for one deglitch code
  task automatic deg(input logic [1:0] code, input int n);
    logic [15:0] v;
    v = {8'h02, 2'b00, code, 4'h8};
    host.wr(8'h30, v);
    settle();
    check(16'({inputSwitchesOff, chargerGoodIndicator}), 16'h1);
    comparatorInput = 1'b1;
    repeat (n - 3) @(posedge clk);
    #5;
    comparatorInput = 1'b0;
    waitOut(1'b0, 10, k);
    check(16'(k), 16'd10);
    comparatorInput = 1'b1;
    waitOut(1'b0, n + 12, k);
    check(16'(k >= n + 2 && k <= n + 8), 16'h1);
    @(posedge clk);
    #5;
    check(16'({inputSwitchesOff, chargerGoodIndicator}), 16'h2);
    comparatorInput = 1'b0;
    waitOut(1'b1, 12, k);
    check(16'(k <= 7), 16'h1);
    host.wr(8'h30, v & 16'hfff7);
    settle();
    check(16'({inputSwitchesOff, chargerGoodIndicator}), 16'h1);
  endtask
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #5;
    nrst = 1'b1;
    host.rd(8'h30, d);
    check(d, 16'h0211);
    check(16'({batEn, sysEn, hot, inSel, chgSel, gain, cmpRef, comparatorOutput, inputSwitchesOff}),
      16'h000a);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      d = r[15:0] & 16'hfff7;
      r = rnd();
      {lowPowerMode, chargerGoodIn} = r[1:0];
      m = chargerGoodIn ? (d & 16'h9fff) : d;
      host.wr(8'h30, d);
      host.rd(8'h30, d);
      check(d, m);
      check(16'(batEn), 16'(m[15] & ~lowPowerMode));
      check(16'(sysEn), 16'(m[12] & ~lowPowerMode));
      check(16'(hot), 16'((m[14:13] == 2'b11) ? 2'b00 : m[14:13]));
      check(16'({inSel, chgSel, gain, cmpRef}), 16'({m[11], m[10], m[9], m[7]}));
      check(16'(chargerGoodIndicator), 16'(chargerGoodIn));
    end
    host.rd(8'h31, d);
    check(d, 16'h0000);
    lowPowerMode  = 1'b0;
    chargerGoodIn = 1'b1;
    host.wr(8'h30, 16'h0200);
    settle();
    comparatorInput = 1'b1;
    waitOut(1'b0, 20, k);
    check(16'(k), 16'd20);
    host.wr(8'h30, 16'h0250);
    comparatorInput = 1'b0;
    waitOut(1'b0, 20, k);
    check(16'(k <= 18), 16'h1);
    host.wr(8'h30, 16'h0200);
    settle();
    deg(2'b01, 10);
    deg(2'b10, MID);
    deg(2'b11, LONG);
    conclude();
  end
  initial begin
    #(5000 * 100);
    errors++;
    conclude();
  end
endmodule
